// >>> hdl/ussr_cfg.svh
`ifndef USSR_CFG_SVH
`define USSR_CFG_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define USSR_IDX_PERIPHERAL_FLAGS_ONE      8'h0c
`define USSR_IDX_RECEIVE_STATUS_CONTROL    8'h18
`define USSR_IDX_TRANSMIT_HOLDING          8'h19
`define USSR_IDX_RECEIVE_BUFFER            8'h1a
`define USSR_IDX_PERIPHERAL_IRQ_ENABLE_ONE 8'h8c
`define USSR_IDX_TRANSMIT_STATUS_CONTROL   8'h98
`define USSR_IDX_BAUD_DIVISOR              8'h99

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define USSR_PIR_RECEIVE_IRQ_FLAG          5
`define USSR_RCS_SERIAL_PORT_ENABLE        7
`define USSR_RCS_NINTH_BIT_RECEIVE_ENABLE  6
`define USSR_RCS_SINGLE_WORD_RECEIVE_EN    5
`define USSR_RCS_CONTINUOUS_RECEIVE_EN     4
`define USSR_RCS_ADDRESS_DETECT_ENABLE     3
`define USSR_RCS_FRAMING_ERROR_FLAG        2
`define USSR_RCS_OVERRUN_ERROR_FLAG        1
`define USSR_RCS_RECEIVED_NINTH_BIT        0
`define USSR_TXS_CLOCK_SOURCE_SELECT       7
`define USSR_TXS_SYNC_MODE                 4
`define USSR_TXS_UNIMPLEMENTED             3
`define USSR_TXS_SHIFT_REGISTER_EMPTY      1

// ----------------------------------------------------------------------------
// Reset values and constants
// ----------------------------------------------------------------------------
`define USSR_RST_BYTE                      8'h00
`define USSR_RST_TRANSMIT_STATUS_CONTROL   8'h02
`define USSR_TXS_WRITE_MASK                8'hf5
`define USSR_RCS_WRITE_MASK                8'hf8
`define USSR_IRQ_VECTOR                    16'h0004

`endif

// >>> hdl/ussr_pkg.sv
package ussr_pkg;

  // --------------------------------------------------------------------------
  // Receiver states
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    USSR_RX_OFF,
    USSR_RX_SHIFT,
    USSR_RX_STALLED
  } ussr_rx_state_t;

endpackage : ussr_pkg

// >>> hdl/ussr_receiver.sv
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`include "ussr_cfg.svh"

module ussr_receiver
  import ussr_pkg::*;
#(
  parameter int unsigned ADDR_W = 12
) (
  // APB
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Link pins
  input  wire logic              link_clk_in,
  input  wire logic              link_data_in,
  // Core side
  input  wire logic              sleep_in,
  input  wire logic              global_irq_enable,
  output logic                   irq,
  output logic                   wake,
  output logic                   branch_req,
  output logic      [15:0]       branch_vector
);

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function automatic logic is_reg(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    is_reg = (a[1:0] == 2'b00) && (a[ADDR_W-1:2] == (ADDR_W-2)'(idx));
  endfunction : is_reg

  // Index of the last bit of a word; the ninth bit extends it
  function automatic logic [3:0] last_bit(input logic nine);
    last_bit = nine ? 4'd8 : 4'd7;
  endfunction : last_bit

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  logic           ck_s1_q,  ck_s2_q,  ck_s3_q;
  logic           dt_s1_q,  dt_s2_q;
  ussr_rx_state_t rx_state_q, rx_state_d;
  logic [8:0]     shift_q,   shift_d;
  logic [3:0]     bit_cnt_q, bit_cnt_d;
  logic [7:0]     rx_buf_q,  rx_buf_d;
  logic           received_ninth_bit_q,    received_ninth_bit_d;
  logic           overrun_error_flag_q,    overrun_error_flag_d;
  logic           receive_irq_flag_q,    receive_irq_flag_d;
  logic [7:0]     rcs_q,     rcs_d;
  logic [7:0]     txs_q,     txs_d;
  logic [7:0]     txh_q,     txh_d;
  logic [7:0]     brg_q,     brg_d;
  logic [7:0]     pie_q,     pie_d;
  logic [31:0]    prdata_q,  prdata_d;
  logic           pready_q,  pready_d;
  logic           pslverr_q, pslverr_d;
  logic           irq_q,     irq_d;
  logic           wake_q,    wake_d;
  logic           br_q,      br_d;
  logic [15:0]    bvec_q,    bvec_d;

  logic           ck_fall;
  logic           rx_enable;
  logic           ninth_en;
  logic           word_done;
  logic           acc;
  logic           wr;
  logic           rd;
  logic           mapped;
  logic [7:0]     rdata;
  logic [7:0]     pir_view;
  logic [7:0]     rcs_view;
  logic [7:0]     txs_view;

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  // Data passes one stage fewer than the clock, as many as the ck_s2_q sample the edge is taken from, so both stay aligned
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ck_s1_q <= 1'b0;
      ck_s2_q <= 1'b0;
      ck_s3_q <= 1'b0;
      dt_s1_q <= 1'b0;
      dt_s2_q <= 1'b0;
    end else begin
      ck_s1_q <= link_clk_in;
      ck_s2_q <= ck_s1_q;
      ck_s3_q <= ck_s2_q;
      dt_s1_q <= link_data_in;
      dt_s2_q <= dt_s1_q;
    end
  end

  // Data sampled on the falling edge of the shift clock
  assign ck_fall = ck_s3_q & ~ck_s2_q;

  // --------------------------------------------------------------------------
  // Register views
  // --------------------------------------------------------------------------
  // Single-word enable is stored but never qualifies reception
  assign rx_enable = rcs_q[`USSR_RCS_SERIAL_PORT_ENABLE]
                   & rcs_q[`USSR_RCS_CONTINUOUS_RECEIVE_EN]
                   & txs_q[`USSR_TXS_SYNC_MODE]
                   & ~txs_q[`USSR_TXS_CLOCK_SOURCE_SELECT];
  assign ninth_en  = rcs_q[`USSR_RCS_NINTH_BIT_RECEIVE_ENABLE];

  always_comb begin
    pir_view = 8'h00;
    pir_view[`USSR_PIR_RECEIVE_IRQ_FLAG] = receive_irq_flag_q;
    rcs_view = rcs_q;
    rcs_view[`USSR_RCS_FRAMING_ERROR_FLAG] = 1'b0;  // No stop bit in sync mode
    rcs_view[`USSR_RCS_OVERRUN_ERROR_FLAG] = overrun_error_flag_q;
    rcs_view[`USSR_RCS_RECEIVED_NINTH_BIT] = received_ninth_bit_q;
    txs_view = txs_q;
    txs_view[`USSR_TXS_UNIMPLEMENTED] = 1'b0;
    txs_view[`USSR_TXS_SHIFT_REGISTER_EMPTY] = 1'b1;  // No transmitter here
  end

  // --------------------------------------------------------------------------
  // APB decode
  // --------------------------------------------------------------------------
  assign acc = psel & penable & pready_q;
  // Every register sits in the low byte lane
  assign wr  = acc & pwrite & pstrb[0];
  assign rd  = acc & ~pwrite;

  always_comb begin
    mapped = 1'b1;
    rdata  = 8'h00;
    if (is_reg(paddr, `USSR_IDX_PERIPHERAL_FLAGS_ONE)) begin
      rdata = pir_view;
    end else if (is_reg(paddr, `USSR_IDX_RECEIVE_STATUS_CONTROL)) begin
      rdata = rcs_view;
    end else if (is_reg(paddr, `USSR_IDX_TRANSMIT_HOLDING)) begin
      rdata = txh_q;
    end else if (is_reg(paddr, `USSR_IDX_RECEIVE_BUFFER)) begin
      rdata = rx_buf_q;
    end else if (is_reg(paddr, `USSR_IDX_PERIPHERAL_IRQ_ENABLE_ONE)) begin
      rdata = pie_q;
    end else if (is_reg(paddr, `USSR_IDX_TRANSMIT_STATUS_CONTROL)) begin
      rdata = txs_view;
    end else if (is_reg(paddr, `USSR_IDX_BAUD_DIVISOR)) begin
      rdata = brg_q;
    end else begin
      mapped = 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    rx_state_d = rx_state_q;
    shift_d    = shift_q;
    bit_cnt_d  = bit_cnt_q;
    rx_buf_d   = rx_buf_q;
    received_ninth_bit_d     = received_ninth_bit_q;
    overrun_error_flag_d     = overrun_error_flag_q;
    receive_irq_flag_d     = receive_irq_flag_q;
    rcs_d      = rcs_q;
    txs_d      = txs_q;
    txh_d      = txh_q;
    brg_d      = brg_q;
    pie_d      = pie_q;
    word_done  = 1'b0;

    // Bus side effects first so hardware events below win
    pready_d  = psel & penable & ~pready_q;
    prdata_d  = prdata_q;
    pslverr_d = 1'b0;
    if (psel & penable & ~pready_q) begin
      prdata_d  = pwrite ? 32'h0000_0000 : {24'h00_0000, rdata};
      pslverr_d = ~mapped;
    end
    if (wr) begin
      if (is_reg(paddr, `USSR_IDX_PERIPHERAL_FLAGS_ONE) && pwdata[`USSR_PIR_RECEIVE_IRQ_FLAG]) begin
        receive_irq_flag_d = 1'b0;
      end
      if (is_reg(paddr, `USSR_IDX_RECEIVE_STATUS_CONTROL)) begin
        rcs_d = pwdata[7:0] & `USSR_RCS_WRITE_MASK;
      end
      if (is_reg(paddr, `USSR_IDX_TRANSMIT_HOLDING)) begin
        txh_d = pwdata[7:0];
      end
      if (is_reg(paddr, `USSR_IDX_PERIPHERAL_IRQ_ENABLE_ONE)) begin
        pie_d = pwdata[7:0];
      end
      if (is_reg(paddr, `USSR_IDX_TRANSMIT_STATUS_CONTROL)) begin
        txs_d = pwdata[7:0] & `USSR_TXS_WRITE_MASK;
      end
      if (is_reg(paddr, `USSR_IDX_BAUD_DIVISOR)) begin
        brg_d = pwdata[7:0];
      end
    end
    // Reading the buffer consumes the word
    if (rd && is_reg(paddr, `USSR_IDX_RECEIVE_BUFFER)) begin
      receive_irq_flag_d = 1'b0;
    end

    case (rx_state_q)
      USSR_RX_OFF: begin
        bit_cnt_d = 4'd0;
        if (rx_enable) begin
          rx_state_d = USSR_RX_SHIFT;
        end
      end
      USSR_RX_SHIFT: begin
        if (!rx_enable) begin
          rx_state_d = USSR_RX_OFF;
        end else if (ck_fall) begin
          shift_d[bit_cnt_q] = dt_s2_q;  // LSB first
          if (bit_cnt_q == last_bit(ninth_en)) begin
            bit_cnt_d = 4'd0;
            word_done = 1'b1;
          end else begin
            bit_cnt_d = bit_cnt_q + 4'd1;
          end
        end
      end
      USSR_RX_STALLED: begin
        // Overrun freezes the shifter until software drops the enable
        bit_cnt_d = 4'd0;
        if (!rx_enable) begin
          rx_state_d = USSR_RX_OFF;
        end
      end
      default: begin
        rx_state_d = USSR_RX_OFF;
      end
    endcase

    // Sleep is not a qualifier: the pin clock keeps shifting
    if (word_done) begin
      // A clear in this cycle frees the buffer, so the new word lands
      if (receive_irq_flag_d) begin
        overrun_error_flag_d     = 1'b1;
        rx_state_d = USSR_RX_STALLED;
      end else begin
        rx_buf_d = shift_d[7:0];
        received_ninth_bit_d   = ninth_en & shift_d[8];
        receive_irq_flag_d   = 1'b1;
      end
    end

    if (!rcs_q[`USSR_RCS_CONTINUOUS_RECEIVE_EN]) begin
      overrun_error_flag_d = 1'b0;
    end

    irq_d  = |(pie_d & {2'b00, receive_irq_flag_d, 5'b0_0000});
    wake_d = sleep_in & irq_d;
    br_d   = irq_d & global_irq_enable;
    // Vector registered beside the request so both change together
    bvec_d = br_d ? `USSR_IRQ_VECTOR : 16'h0000;
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state_q <= USSR_RX_OFF;
      shift_q    <= 9'h000;
      bit_cnt_q  <= 4'd0;
      rx_buf_q   <= `USSR_RST_BYTE;
      received_ninth_bit_q     <= 1'b0;
      overrun_error_flag_q     <= 1'b0;
      receive_irq_flag_q     <= 1'b0;
      rcs_q      <= `USSR_RST_BYTE;
      txs_q      <= `USSR_RST_BYTE;
      txh_q      <= `USSR_RST_BYTE;
      brg_q      <= `USSR_RST_BYTE;
      pie_q      <= `USSR_RST_BYTE;
      prdata_q   <= 32'h0000_0000;
      pready_q   <= 1'b0;
      pslverr_q  <= 1'b0;
      irq_q      <= 1'b0;
      wake_q     <= 1'b0;
      br_q       <= 1'b0;
      bvec_q     <= 16'h0000;
    end else begin
      rx_state_q <= rx_state_d;
      shift_q    <= shift_d;
      bit_cnt_q  <= bit_cnt_d;
      rx_buf_q   <= rx_buf_d;
      received_ninth_bit_q     <= received_ninth_bit_d;
      overrun_error_flag_q     <= overrun_error_flag_d;
      receive_irq_flag_q     <= receive_irq_flag_d;
      rcs_q      <= rcs_d;
      txs_q      <= txs_d;
      txh_q      <= txh_d;
      brg_q      <= brg_d;
      pie_q      <= pie_d;
      prdata_q   <= prdata_d;
      pready_q   <= pready_d;
      pslverr_q  <= pslverr_d;
      irq_q      <= irq_d;
      wake_q     <= wake_d;
      br_q       <= br_d;
      bvec_q     <= bvec_d;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  // Every output leaves a flop, so the core sees no glitches
  assign prdata        = prdata_q;
  assign pready        = pready_q;
  assign pslverr       = pslverr_q;
  assign irq           = irq_q;
  assign wake          = wake_q;
  assign branch_req    = br_q;
  assign branch_vector = bvec_q;

endmodule : ussr_receiver

// >>> tb/tb_usart_sync_slave_receive.sv
`timescale 1ns/1ps
module tb_usart_sync_slave_receive;
  localparam logic [11:0] PIR = 12'h030, RCS = 12'h060, TXH = 12'h064, RCB = 12'h068;
  localparam logic [11:0] PIE = 12'h230, TXS = 12'h260, BRG = 12'h264;
  localparam logic [11:0] RA[8] = '{PIR, RCS, TXH, RCB, PIE, TXS, BRG, 12'h004};
  localparam logic [32:0] RV[8] = '{0, 0, 0, 0, 0, 33'h02, 0, 33'h1_0000_0000};
  localparam logic [11:0] RW[3] = '{TXH, BRG, PIE};
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        lclk, ldat, sleep_in, gie, irq, wake, breq;
  logic [11:0] paddr;
  logic [3:0]  pstrb;
  logic [31:0] pwdata, prdata;
  logic [15:0] bvec;
  logic [7:0]  b;
  logic [32:0] exp_q[$];
  int          n_mismatch, checked, seed = 15;

  ussr_receiver #(.ADDR_W(12)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .link_clk_in(lclk), .link_data_in(ldat), .sleep_in,
    .global_irq_enable(gie), .irq, .wake, .branch_req(breq), .branch_vector(bvec));
  ussr_link_master i_lm (.link_clk(lclk), .link_data(ldat));

  task automatic stop_test;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [32:0] g, input logic [32:0] e);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  // Reads leave their expectation for the watcher below
  task automatic apb(input logic w, input logic [11:0] a, input logic [32:0] e);
    int k;
    if (!w)
      exp_q.push_back(e);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= e[31:0];
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k == 50) begin
      n_mismatch++;
      stop_test();
    end
  endtask : apb

  task automatic wait_irq;
    int k;
    for (k = 0; k < 400 && irq !== 1'b1; k++)
      @(posedge pclk);
    if (k == 400) begin
      n_mismatch++;
      stop_test();
    end
  endtask : wait_irq

  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && !pwrite)
      chk({pslverr, prdata}, exp_q.pop_front());

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  initial begin
    {presetn, psel, penable, pwrite, sleep_in, gie} = '0;
    paddr  = '0;
    pwdata = '0;
    pstrb  = 4'h1;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    foreach (RA[i]) apb(0, RA[i], RV[i]);
    foreach (RW[i]) begin
      b = $random(seed) & 8'h7f;
      apb(1, RW[i], b);
      apb(0, RW[i], b);
    end
    apb(1, TXS, 33'hff);
    apb(0, TXS, 33'hf7);
    apb(1, TXS, 33'h10);
    apb(1, TXH, 33'h3c);
    pstrb <= 4'h0;
    apb(1, TXH, 33'hc3);
    pstrb <= 4'h1;
    apb(0, TXH, 33'h3c);
    $display("end registers");
    apb(1, PIE, 33'h20);
    apb(1, RCS, 33'hb0);
    b = $random(seed);
    i_lm.send(b, 8);
    wait_irq();
    chk(breq, 0);
    apb(0, PIR, 33'h20);
    apb(0, RCB, b);
    apb(0, PIR, 0);
    $display("end plain word");
    sleep_in <= 1'b1;
    gie      <= 1'b1;
    b = $random(seed);
    i_lm.send(b, 8);
    wait_irq();
    repeat (2) @(posedge pclk);
    chk({wake, breq, bvec}, 18'h3_0004);
    apb(0, RCB, b);
    sleep_in <= 1'b0;
    $display("end sleep word");
    apb(1, PIE, 0);
    b = $random(seed);
    i_lm.send(b, 8);
    repeat (30) @(posedge pclk);
    chk(irq, 0);
    apb(1, PIE, 33'h20);
    wait_irq();
    i_lm.send(~b, 8);
    repeat (30) @(posedge pclk);
    apb(0, RCS, 33'hb2);
    apb(1, PIR, 33'h20);
    apb(0, PIR, 0);
    chk(irq, 0);
    apb(0, RCB, b);
    apb(1, RCS, 33'h80);
    apb(0, RCS, 33'h80);
    i_lm.send(b, 8);
    repeat (30) @(posedge pclk);
    apb(0, PIR, 0);
    $display("end overrun");
    apb(1, RCS, 33'hd0);
    b = $random(seed);
    i_lm.send({1'b1, b}, 9);
    wait_irq();
    apb(0, RCS, 33'hd1);
    apb(0, RCB, b);
    $display("end nine bits");
    repeat (4) @(posedge pclk);
    stop_test();
  end
endmodule : tb_usart_sync_slave_receive

bind ussr_receiver ussr_monitor #(.ADDR_W(ADDR_W)) i_mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pstrb, .prdata, .pready, .pslverr, .link_clk_in, .link_data_in, .sleep_in, .global_irq_enable,
  .irq, .wake, .branch_req, .branch_vector);

// >>> tb/ussr_link_master.sv
`timescale 1ns/1ps
module ussr_link_master (
  // Link pins
  output logic link_clk,
  output logic link_data
);
  initial begin
    link_clk  = 1'b1;
    link_data = 1'b1;
  end

  // Clock runs only within a word; data is not held after it
  task automatic send(input logic [8:0] w, input int n);
    for (int i = 0; i < n; i++) begin
      link_data = w[i];
      #16 link_clk = 1'b0;
      #32 link_clk = 1'b1;
      #16;
    end
    link_data = ~link_data;
  endtask : send
endmodule : ussr_link_master

// >>> tb/ussr_monitor.sv
`timescale 1ns/1ps
module ussr_monitor #(
  parameter int unsigned ADDR_W = 12
) (
  // APB
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // Link and core
  input wire logic              link_clk_in,
  input wire logic              link_data_in,
  input wire logic              sleep_in,
  input wire logic              global_irq_enable,
  input wire logic              irq,
  input wire logic              wake,
  input wire logic              branch_req,
  input wire logic [15:0]       branch_vector
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  pready_wait_a: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("answer not on second edge");
  pready_once_a: assert property (pready |=> !pready)
    else $error("answer held too long");
  slverr_gate_a: assert property (pslverr |-> pready)
    else $error("error without answer");
  rdata_upper_a: assert property (pready |-> prdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  vector_value_a: assert property (branch_vector == (branch_req ? 16'h0004 : 16'h0000))
    else $error("vector wrong");
  branch_gate_a: assert property (branch_req |-> $past(global_irq_enable) || $past(global_irq_enable, 2))
    else $error("branch without global enable");
  wake_sleep_a: assert property (wake |-> $past(sleep_in) || $past(sleep_in, 2))
    else $error("wake while awake");
  wake_cause_a: assert property (wake |-> irq || $past(irq))
    else $error("wake without interrupt");
  irq_drop_a: assert property ($fell(irq) |-> $past(pready) || $past(pready, 2))
    else $error("interrupt fell without access");
endmodule : ussr_monitor
